// file: logic/strobe_host_pkg.sv
package strobe_host_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 17;            // Address bits 0..16
  localparam int DATA_W = 16;            // Two byte lanes

  // ---------------------------------------------------------------
  // Reset values and strap encodings
  // ---------------------------------------------------------------
  localparam logic       ENDIAN_LITTLE  = 1'h0;   // Strap low: little endian
  localparam logic       ENDIAN_BIG     = 1'h1;   // Strap high: big endian
  localparam logic       MODE_STROBE    = 1'h0;   // Bus status strap low: strobe mode
  localparam logic [15:0] RDATA_RST     = 16'h0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SYNC_STAGES = 2;        // Flip-flops in each pin synchroniser

  // ---------------------------------------------------------------
  // Access sequencer states (Gray along the usual path)
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_DONE = 2'b11,
    ST_END  = 2'b10
  } acc_state_e;

endpackage : strobe_host_pkg

// file: logic/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser, one per bit; stage one feeds only stage two
module pin_sync #(
  parameter int W   = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import strobe_host_pkg::*;

  logic [W-1:0] meta_ff;                 // First stage, read only by second
  logic [W-1:0] sync_ff;                 // Second stage
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // ---------------------------------------------------------------
  // Next values
  // ---------------------------------------------------------------
  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;

endmodule : pin_sync

// file: logic/strobe_host_bus_port.sv
`timescale 1ns/1ps
module strobe_host_bus_port (
  // Core clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // Host bus pins
  input  wire logic                          host_bus_clock,
  input  wire logic                          chip_sel_n,
  input  wire logic [strobe_host_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [strobe_host_pkg::DATA_W-1:0] data_in,
  output logic      [strobe_host_pkg::DATA_W-1:0] data_out,
  output logic      [strobe_host_pkg::DATA_W-1:0] data_oe,
  input  wire logic                          write_low_n,
  input  wire logic                          write_high_n,
  input  wire logic                          read_low_n,
  input  wire logic                          read_high_n,
  output logic                               host_hold_n,
  // Straps
  input  wire logic                          endian_strap,
  input  wire logic                          bus_status_strap,
  output logic                               big_endian,
  output logic                               strobe_mode,
  // Internal memory/register request
  output logic                               mem_req,
  output logic                               mem_we,
  output logic      [strobe_host_pkg::ADDR_W-1:0] mem_addr,
  output logic      [strobe_host_pkg::DATA_W-1:0] mem_wdata,
  output logic      [1:0]                    mem_be,
  input  wire logic                          mem_grant,
  input  wire logic [strobe_host_pkg::DATA_W-1:0] mem_rdata
);
  import strobe_host_pkg::*;

  // ---------------------------------------------------------------
  // Synchronised host pins
  // ---------------------------------------------------------------
  logic       bclk_s;                    // Synchronised bus clock
  logic       cs_s;                      // Chip select, active high internally
  logic [3:0] stb_s;                     // {rd_hi, rd_lo, wr_hi, wr_lo}, active high
  logic [1:0] strap_s;                   // {bus status, endian}
  logic [ADDR_W-1:0] addr_s;             // Synchronised address, same lag as the strobes
  logic [DATA_W-1:0] wdata_s;            // Synchronised write data, same lag as the strobes

  pin_sync #(.W(1), .INIT(1'h0)) u_clk_sync (
    .clk(clk), .srst(srst), .din(host_bus_clock), .dout(bclk_s));
  pin_sync #(.W(5), .INIT(5'h00)) u_ctl_sync (
    .clk(clk), .srst(srst),
    .din({~chip_sel_n, ~read_high_n, ~read_low_n, ~write_high_n, ~write_low_n}),
    .dout({cs_s, stb_s}));
  // Straps settle through this pair while reset holds, so it is never cleared;
  // clearing it would hand the capture a stale zero at reset release
  pin_sync #(.W(2), .INIT(2'h0)) u_strap_sync (
    .clk(clk), .srst(1'b0), .din({bus_status_strap, endian_strap}), .dout(strap_s));
  // Address and data pass the same two stages, so they line up with the strobes
  pin_sync #(.W(ADDR_W), .INIT('0)) u_addr_sync (
    .clk(clk), .srst(srst), .din(addr_in), .dout(addr_s));
  pin_sync #(.W(DATA_W), .INIT('0)) u_data_sync (
    .clk(clk), .srst(srst), .din(data_in), .dout(wdata_s));

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  acc_state_e              state_ff,  nxt_state;
  logic                    bclk_d_ff, nxt_bclk_d;     // Previous bus clock level
  logic                    rst_d_ff,  nxt_rst_d;      // Reset seen last cycle
  logic                    big_ff,    nxt_big;        // Captured endian mode
  logic                    mode_ff,   nxt_mode;       // Captured strobe mode
  logic                    we_ff,     nxt_we;
  logic [1:0]              be_ff,     nxt_be;
  logic [ADDR_W-1:0]       addr_ff,   nxt_addr;
  logic [DATA_W-1:0]       wdata_ff,  nxt_wdata;
  logic [DATA_W-1:0]       rdata_ff,  nxt_rdata;
  logic [DATA_W-1:0]       oe_ff,     nxt_oe;
  logic                    hold_ff,   nxt_hold;       // Hold-off asserted, active high

  logic bclk_rise;
  logic rd_any;
  logic wr_any;

  assign bclk_rise = bclk_s & ~bclk_d_ff;
  assign rd_any    = stb_s[2] | stb_s[3];
  assign wr_any    = stb_s[0] | stb_s[1];

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_bclk_d = bclk_s;
    nxt_rst_d  = 1'b0;
    nxt_big    = big_ff;
    nxt_mode   = mode_ff;
    nxt_we     = we_ff;
    nxt_be     = be_ff;
    nxt_addr   = addr_ff;
    nxt_wdata  = wdata_ff;
    nxt_rdata  = rdata_ff;
    nxt_oe     = oe_ff;
    nxt_hold   = hold_ff;
    // Straps are taken once, the first cycle after reset release
    if (rst_d_ff) begin
      nxt_big  = strap_s[0];
      nxt_mode = (strap_s[1] == MODE_STROBE);
    end
    case (state_ff)
      ST_IDLE: begin
        // Access start sampled on rising bus clock edges only; select must qualify a strobe
        if (bclk_rise && cs_s && (rd_any || wr_any) && mode_ff) begin
          nxt_state = ST_REQ;
          nxt_hold  = 1'b1;
          nxt_we    = wr_any;
          nxt_be    = wr_any ? stb_s[1:0] : stb_s[3:2];
          nxt_addr  = addr_s;
          nxt_wdata = wdata_s;
        end
      end
      ST_REQ: begin
        // Hold-off stays low while display refresh owns the memory
        if (mem_grant) begin
          nxt_state = ST_DONE;
          nxt_hold  = 1'b0;
          if (!we_ff) begin
            // Only strobed lanes are driven back to the host
            nxt_rdata = mem_rdata;
            nxt_oe    = {{8{be_ff[1]}}, {8{be_ff[0]}}};
          end
        end
      end
      ST_DONE: begin
        // Data stands until the host drops its strobes or select
        if (!cs_s || !(rd_any || wr_any)) begin
          nxt_state = ST_END;
          nxt_oe    = '0;
        end
      end
      ST_END: nxt_state = ST_IDLE;
      default: begin
        nxt_state = ST_IDLE;
        nxt_hold  = 1'b0;
        nxt_oe    = '0;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff  <= ST_IDLE;
      bclk_d_ff <= 1'b0;
      rst_d_ff  <= 1'b1;
      big_ff    <= ENDIAN_LITTLE;
      mode_ff   <= 1'b1;
      we_ff     <= 1'b0;
      be_ff     <= 2'h0;
      addr_ff   <= '0;
      wdata_ff  <= RDATA_RST;
      rdata_ff  <= RDATA_RST;
      oe_ff     <= '0;
      hold_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      bclk_d_ff <= nxt_bclk_d;
      rst_d_ff  <= nxt_rst_d;
      big_ff    <= nxt_big;
      mode_ff   <= nxt_mode;
      we_ff     <= nxt_we;
      be_ff     <= nxt_be;
      addr_ff   <= nxt_addr;
      wdata_ff  <= nxt_wdata;
      rdata_ff  <= nxt_rdata;
      oe_ff     <= nxt_oe;
      hold_ff   <= nxt_hold;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign host_hold_n = ~hold_ff;
  assign data_out    = rdata_ff;
  assign data_oe     = oe_ff;
  assign big_endian  = big_ff;
  assign strobe_mode = mode_ff;
  assign mem_req     = (state_ff == ST_REQ);
  assign mem_we      = we_ff;
  assign mem_addr    = addr_ff;
  assign mem_wdata   = wdata_ff;
  assign mem_be      = be_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_wait_grant;
    mem_req && !mem_grant;
  endsequence

  property p_hold_while_req;
    @(posedge clk) disable iff (srst) s_wait_grant |-> !host_hold_n;
  endproperty
  a_hold_while_req: assert property (p_hold_while_req)
    else $error("hold-off released before grant");

  property p_release_after_grant;
    @(posedge clk) disable iff (srst) (mem_req && mem_grant) |=> host_hold_n;
  endproperty
  a_release_after_grant: assert property (p_release_after_grant)
    else $error("hold-off not released after grant");

  property p_oe_lanes;
    @(posedge clk) disable iff (srst)
      (mem_req && mem_grant && !mem_we) |=> (data_oe == {{8{mem_be[1]}}, {8{mem_be[0]}}});
  endproperty
  a_oe_lanes: assert property (p_oe_lanes)
    else $error("read lanes do not follow strobes");

  property p_no_oe_on_write;
    @(posedge clk) disable iff (srst) mem_we |-> (data_oe == '0);
  endproperty
  a_no_oe_on_write: assert property (p_no_oe_on_write)
    else $error("data driven during write");

  property p_start_needs_select;
    @(posedge clk) disable iff (srst) $rose(mem_req) |-> $past(cs_s);
  endproperty
  a_start_needs_select: assert property (p_start_needs_select)
    else $error("access started without chip select");

  property p_strap_capture;
    @(posedge clk) disable iff (srst) $fell(rst_d_ff) |-> big_endian == $past(strap_s[0]);
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("endian strap not captured");

  property p_hold_on_start;
    @(posedge clk) disable iff (srst) $rose(mem_req) |-> !host_hold_n;
  endproperty
  a_hold_on_start: assert property (p_hold_on_start)
    else $error("hold-off not low at access start");

  property p_be_nonzero;
    @(posedge clk) disable iff (srst) mem_req |-> (mem_be != 2'h0);
  endproperty
  a_be_nonzero: assert property (p_be_nonzero)
    else $error("access with no byte lane");

endmodule : strobe_host_bus_port

// file: tb/cs_timing_model.sv
`timescale 1ns/1ps
// Processor select machine plus the inverting glue stage on the acknowledge line
module cs_timing_model #(
  parameter logic BURST_INHIBIT = 1'b1  // Window programmed to inhibit bursts
) (
  // From the port, plus the bus clock and the test settings
  input  wire logic                               host_bus_clock,
  input  wire logic                               host_hold_n,
  input  wire logic [strobe_host_pkg::DATA_W-1:0] data_out,
  input  wire logic [strobe_host_pkg::DATA_W-1:0] data_oe,
  input  wire logic                               relaxed_timing,
  input  wire logic [1:0]                         cs_assert_delay,
  input  wire logic                               early_negate,
  input  wire logic                               extra_hold_first,
  // Burst inhibit seen by the processor while this window is selected
  output logic                                    no_burst_flag,
  // To the port
  output logic                                    chip_sel_n,
  output logic      [strobe_host_pkg::ADDR_W-1:0] addr_in,
  output logic      [strobe_host_pkg::DATA_W-1:0] data_in,
  output logic                                    write_low_n,
  output logic                                    write_high_n,
  output logic                                    read_low_n,
  output logic                                    read_high_n
);
  import strobe_host_pkg::*;
  logic [DATA_W-1:0] drv_data;  // Host write data
  logic              drv_en;    // Host drives the data lines
  logic [DATA_W-1:0] last_bus;  // Last settled bus value
  logic              ack_n;     // Acknowledge, low true
  logic              first_done; // First access to this select has been made
  localparam realtime QUARTER_NS = 12.0;  // A quarter of the 48 ns bus clock
  assign no_burst_flag = BURST_INHIBIT & ~chip_sel_n;
  // Glue drives only while selected; a pull-up holds the line high otherwise
  assign ack_n = chip_sel_n ? 1'b1 : ~host_hold_n;
  // No pull on data lines: a floating bit shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      data_in[i] = data_oe[i] ? data_out[i] : (drv_en ? drv_data[i] : ~last_bus[i]);
    end
  end
  always @(posedge host_bus_clock) last_bus <= data_in;
  initial begin
    {chip_sel_n, write_low_n, write_high_n, read_low_n, read_high_n} = 5'h1F;
    addr_in = '0;
    drv_data = '0;
    drv_en = 1'b0;
    first_done = 1'b0;
  end
  // One normal cycle: two bus clocks at least, one and a half with early negate, then ends on acknowledge
  task automatic access(input logic we, input logic [1:0] be, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
                        output logic [DATA_W-1:0] oe, output logic ok);
    int n;
    @(posedge host_bus_clock);
    addr_in <= a;
    if (relaxed_timing) @(posedge host_bus_clock);
    if (extra_hold_first && !first_done) @(posedge host_bus_clock);
    first_done = 1'b1;
    // Select and strobes follow the address by none, a quarter or half a clock
    if (cs_assert_delay == 2'h1) #(QUARTER_NS);
    else if (cs_assert_delay[1]) @(negedge host_bus_clock);
    chip_sel_n   <= 1'b0;
    write_low_n  <= ~(we & be[0]);
    write_high_n <= ~(we & be[1]);
    read_low_n   <= ~(~we & be[0]);
    read_high_n  <= ~(~we & be[1]);
    drv_data     <= wd;
    drv_en       <= we;
    n = 0;
    do begin
      @(posedge host_bus_clock);
      n++;
      // Early negate samples and lets go half a clock ahead of the nominal end
      if (early_negate) @(negedge host_bus_clock);
    end while (n < (early_negate ? 1 : 2) || (ack_n && n < 30));
    rd = data_in;
    oe = data_oe;
    ok = ~ack_n;
    {chip_sel_n, write_low_n, write_high_n, read_low_n, read_high_n} <= 5'h1F;
    drv_en <= 1'b0;
  endtask : access
endmodule : cs_timing_model

// file: tb/test_strobe_host_bus_port.sv
`timescale 1ns/1ps
module test_strobe_host_bus_port;
  import strobe_host_pkg::*;
  logic clk, srst, host_bus_clock, chip_sel_n, host_hold_n, relaxed_timing;
  logic early_negate, extra_hold_first, no_burst_flag;
  logic [1:0]        cs_assert_delay;
  logic write_low_n, write_high_n, read_low_n, read_high_n;
  logic endian_strap, bus_status_strap, big_endian, strobe_mode;
  logic mem_req, mem_we, mem_grant, cur_we, req_seen;
  logic [1:0]        mem_be, cur_be;
  logic [ADDR_W-1:0] addr_in, mem_addr, cur_a;
  logic [DATA_W-1:0] data_in, data_out, data_oe, mem_wdata, mem_rdata, cur_wd, rd, oe;
  logic [DATA_W-1:0] mem [16];  // Responder storage
  logic [DATA_W-1:0] exp [16];  // Expected contents
  logic              ok;
  int failures, cmp_count, seed, gwait;
  strobe_host_bus_port strobe_host_bus_port_i (.*);
  cs_timing_model cs_timing_model_i (.*);
  // Core clock 5 ns; bus clock 48 ns, free running like the processor clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    host_bus_clock = 1'b0;
    forever #24 host_bus_clock = ~host_bus_clock;
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Arbiter stand-in: grants after a random delay, checks the request fields
  always @(negedge clk) begin
    mem_grant <= 1'b0;
    if (mem_req && !mem_grant) begin
      req_seen <= 1'b1;
      chk("hold while pending", 0, host_hold_n);
      chk("no-burst flag", 1, no_burst_flag);
      if (gwait == 0) begin
        mem_grant <= 1'b1;
        chk("request kind", {cur_we, cur_be, cur_a}, {mem_we, mem_be, mem_addr});
        if (mem_we) begin
          chk("write data", cur_wd & exp_mask(cur_be), mem_wdata & exp_mask(cur_be));
          mem[mem_addr[3:0]] <= (mem[mem_addr[3:0]] & ~exp_mask(mem_be))
                                | (mem_wdata & exp_mask(mem_be));
        end
        mem_rdata <= mem[mem_addr[3:0]];
      end else gwait <= gwait - 1;
    end
  end
  function automatic logic [DATA_W-1:0] exp_mask(input logic [1:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction : exp_mask
  task automatic do_reset(input logic en, input logic bs);
    @(negedge clk);
    srst = 1'b1;
    endian_strap = en;
    bus_status_strap = bs;
    repeat (12) @(negedge clk);
    chk("hold in reset", 1, host_hold_n);
    srst = 1'b0;
    repeat (6) @(negedge clk);
    chk("straps", {en, ~bs}, {big_endian, strobe_mode});
    endian_strap = ~en;
  endtask : do_reset
  // One access through the model, with expectations from the lane strobes
  task automatic op(input logic we, input logic [1:0] be, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] wd);
    @(negedge clk);
    {cur_we, cur_be, cur_a, cur_wd} = {we, be, a, wd};
    // Long grants keep the hold-off low past the two-clock minimum
    gwait = {$random(seed)} % 41;
    relaxed_timing = $random(seed);
    {cs_assert_delay, early_negate} = 3'($random(seed));
    cs_timing_model_i.access(we, be, a, wd, rd, oe, ok);
    chk("acknowledge", 1, ok);
    chk("lane enables", we ? '0 : exp_mask(be), oe);
    if (we) exp[a[3:0]] = (exp[a[3:0]] & ~exp_mask(be)) | (wd & exp_mask(be));
    else chk("read data", exp[a[3:0]] & exp_mask(be), rd & exp_mask(be));
  endtask : op
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  initial begin
    seed = 74890;
    srst = 1'b1;
    {relaxed_timing, mem_grant, req_seen, gwait} = '0;
    {cs_assert_delay, early_negate} = 3'h0;
    extra_hold_first = 1'b1;
    mem_rdata = '0;
    for (int i = 0; i < 16; i++) begin
      mem[i] = '0;
      exp[i] = '0;
    end
    do_reset(1'b0, MODE_STROBE);
    // Every lane code both ways at the top address, then random traffic
    for (int b = 1; b < 4; b++) op(1'b1, b[1:0], 17'h1FFFF, $random(seed));
    for (int b = 1; b < 4; b++) op(1'b0, b[1:0], 17'h1FFFF, '0);
    repeat (60) op($random(seed), 2'h1 + 2'({$random(seed)} % 3), $random(seed), $random(seed));
    do_reset(1'b1, MODE_STROBE);
    chk("strap held", 1, big_endian);
    op(1'b0, 2'h3, 17'h00000, '0);
    // Strap high: strobes must be ignored
    do_reset(1'b0, ~MODE_STROBE);
    req_seen = 1'b0;
    cs_timing_model_i.access(1'b0, 2'h3, 17'h00000, '0, rd, oe, ok);
    chk("ignored access", 0, {req_seen, oe});
    wrap_up();
  end
endmodule : test_strobe_host_bus_port
